// *** usb_sie_regs.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: word-indexed register bus, one byte of data per word
// Notes:   definitions only
`ifndef USB_SIE_REGS_SVH
`define USB_SIE_REGS_SVH
// register word indices
`define OFF_MAIN_CTRL 14'h0000
`define OFF_CONFIG    14'h0001
`define OFF_EVENTS    14'h0002
`define OFF_STATUS    14'h0003
`define OFF_ADDRESS   14'h0004
`define OFF_FRAME_LO  14'h0005
`define OFF_FRAME_HI  14'h0006
`define OFF_EP_BASE   14'h0008
`define OFF_EP_LAST   14'h000F
// memory map
`define DP_LIN_BASE   14'h2000
`define DP_LIN_LAST   14'h21EF
`define DP_BNK_BASE   14'h0370
`define DP_BNK_LAST   14'h037F
`define DP_BNK_HI     5'h1F
`define SP_BASE       14'h2200
`define SP_LAST       14'h23FF
`define UNIMP_BASE    14'h2400
`define UNIMP_LAST    14'h29AF
// field positions
`define CTRL_EN       0
`define CTRL_SUSP     1
`define CTRL_CONF     2
`define CFG_FS        2
`define CFG_PU        4
`define CFG_EYE       7
`define CFG_MASK      8'h97
`define EVT_TRN       0
`define EVT_RST       1
`define EP_STALL      0
`define EP_IN         1
`define EP_OUT        2
`define EP_CDIS       3
`define EP_HSHK       4
// reset values
`define CTRL_RST      3'h0
`define CFG_RST       8'h00
`define ADDR_RST      7'h00
`define EP_RST        5'h00
`define FRM_RST       11'h000
// timing
`define CLK_NS        50
`define TCY_NS        83
`define TRN_REARM_TCY 6
`define TRN_REARM_CYC ((`TRN_REARM_TCY * `TCY_NS) / `CLK_NS)
`define FIFO_DEPTH    3'h4
`endif

// *** usb_sie_pkg.sv ***
// Purpose: types shared by the engine-side ports
// Assumes: engine logic on the same clock
// Notes:   no constants here, see usb_sie_regs.svh
package usb_sie_pkg;
  typedef enum logic [1:0] {
    TOK_OUT   = 2'b00,
    TOK_IN    = 2'b01,
    TOK_SETUP = 2'b10,
    TOK_SOF   = 2'b11
  } tok_kind_t;
  typedef struct packed {
    logic        valid;
    tok_kind_t   kind;
    logic [6:0]  addr;
    logic [3:0]  endp;
    logic [10:0] frame;
  } token_t;
  typedef struct packed {
    logic valid;
    logic accept;
    logic nak;
    logic handshake;
  } reply_t;
  typedef struct packed {
    logic       valid;
    logic [3:0] endp;
    logic       dir;
    logic       pingpong_pointer;
  } done_t;
  typedef struct packed {
    logic       valid;
    logic [2:0] endp;
  } stall_t;
  typedef struct packed {
    logic enable;
    logic full_speed;
    logic dp_pullup;
    logic dm_pullup;
    logic tx_oe;
    logic tx_dp;
    logic tx_dm;
  } xcvr_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;
endpackage : usb_sie_pkg

// *** usb_device_sie_config_status.sv ***
// Purpose: usb engine configuration, status fifo, endpoints, address,
//          frame number and usb ram map behind an avalon-mm slave
// Assumes: engine events arrive on clk_sys_i, one cycle pulses
// Notes:   every bus access answers in two cycles
//
// What this block does
// - full-speed select bit picks full or low speed transceiver
// - transceiver enabled whenever module enable is set
// - pull-ups only with pull-up enable, module enable and configured
// - eye test sends alternating J/K while enabled, starting per speed
// - status register shows head of fifo of completed transactions
// - status contents valid in the same clock the completion flag rises
// - clearing completion flag pops fifo, flag returns within 6 cycles
// - empty fifo after pop keeps the completion flag clear
// - accepted tokens arriving while the status fifo is full get NAK
// - one identical control register per endpoint pair
// - handshakes only when endpoint handshake enable is set
// - setup accepted only while control disable is clear
// - out needs out enable, in needs in enable
// - stall sent sets stall flag, held until firmware or reset clears
// - respond only to own address; bus or device reset clears it
// - sof captures 11-bit frame number into two read-only registers
// - frame number need not track while engine clock is stopped
// - dual-port ram 2000h-21EFh linear plus 16 bytes at 370h
// - cpu-only ram 2200h-23FFh; 2400h-29AFh reads zero
// - setting module enable clears all ping-pong pointers
// - suspend stops the engine clock
`timescale 1ns/1ps
`include "usb_sie_regs.svh"

module usb_device_sie_config_status (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire logic [13:0]          avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  output logic      [31:0]          avs_readdata_o,
  output logic                      avs_waitrequest_o,
  input  wire usb_sie_pkg::token_t  token_i,
  output usb_sie_pkg::reply_t       reply_o,
  input  wire usb_sie_pkg::done_t   done_i,
  input  wire usb_sie_pkg::stall_t  stall_i,
  input  wire logic                 bus_reset_i,
  input  wire logic [8:0]           eng_ram_addr_i,
  input  wire logic                 eng_ram_we_i,
  input  wire logic [7:0]           eng_ram_wdata_i,
  output logic      [7:0]           eng_ram_rdata_o,
  output usb_sie_pkg::xcvr_t        xcvr_o,
  output logic      [1:0]           pingpong_config_o,
  output logic                      pingpong_clear_o,
  output logic                      sie_clk_run_o
);

  localparam int TRN_MAX = `TRN_REARM_CYC;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  usb_sie_pkg::bus_state_t bus_state_reg;
  logic [2:0]  ctrl_reg;
  logic [7:0]  cfg_reg;
  logic [6:0]  addr_reg;
  logic [10:0] frm_reg;
  logic [4:0]  ep_reg [0:7];
  logic        trn_flag_reg;
  logic        rst_flag_reg;
  logic [5:0]  fifo_mem [0:3];
  logic [1:0]  rd_ptr_reg;
  logic [1:0]  wr_ptr_reg;
  logic [2:0]  count_reg;
  logic [7:0]  status_reg;
  logic [7:0]  dp_ram [0:511];
  logic [7:0]  sp_ram [0:511];
  logic [7:0]  eng_rdata_next;
  logic        eye_phase_reg;
  logic        wr_en;
  logic        running;
  logic        push;
  logic        pop;
  logic        fifo_full;
  logic        dp_hit;
  logic        bk_hit;
  logic        sp_hit;
  logic        unimp_hit;
  logic        ep_hit;
  logic [8:0]  dp_idx;
  logic [8:0]  sp_idx;
  logic [7:0]  rd_byte;
  logic [4:0]  tok_ep;
  logic        tok_ok;
  logic        acc_c;
  logic        pu_c;
  logic        eye_c;

  // ************************************************************
  // register bus
  // ************************************************************

  // a write lands on the edge where waitrequest is seen low
  assign wr_en   = avs_write_i && (bus_state_reg == usb_sie_pkg::BUS_ACK);
  assign running = ctrl_reg[`CTRL_EN] && !ctrl_reg[`CTRL_SUSP];

  // one wait cycle, then one answer cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : bus_fsm
    if (!rst_n_i) begin
      bus_state_reg     <= usb_sie_pkg::BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else begin
      case (bus_state_reg)
        usb_sie_pkg::BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_state_reg     <= usb_sie_pkg::BUS_ACK;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= {24'h000000, rd_byte};
          end
        end
        usb_sie_pkg::BUS_ACK: begin
          bus_state_reg     <= usb_sie_pkg::BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_state_reg     <= usb_sie_pkg::BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // address decode of the data-space map
  always_comb begin : map_decode
    dp_hit    = (avs_address_i >= `DP_LIN_BASE) &&
                (avs_address_i <= `DP_LIN_LAST);
    bk_hit    = (avs_address_i >= `DP_BNK_BASE) &&
                (avs_address_i <= `DP_BNK_LAST);
    sp_hit    = (avs_address_i >= `SP_BASE) &&
                (avs_address_i <= `SP_LAST);
    unimp_hit = (avs_address_i >= `UNIMP_BASE) &&
                (avs_address_i <= `UNIMP_LAST);
    ep_hit    = (avs_address_i >= `OFF_EP_BASE) &&
                (avs_address_i <= `OFF_EP_LAST);
    // banked window is the top 16 bytes of the dual-port array
    dp_idx    = bk_hit ? {`DP_BNK_HI, avs_address_i[3:0]}
                       : 9'(avs_address_i - `DP_LIN_BASE);
    sp_idx    = 9'(avs_address_i - `SP_BASE);
  end

  // read mux; unmapped words read zero
  always_comb begin : read_mux
    rd_byte = 8'h00;
    if (dp_hit || bk_hit) begin
      rd_byte = dp_ram[dp_idx];
    end else if (sp_hit) begin
      rd_byte = sp_ram[sp_idx];
    end else if (unimp_hit) begin
      rd_byte = 8'h00;
    end else if (ep_hit) begin
      rd_byte = {3'h0, ep_reg[avs_address_i[2:0]]};
    end else begin
      case (avs_address_i)
        `OFF_MAIN_CTRL: rd_byte = {5'h00, ctrl_reg};
        `OFF_CONFIG:    rd_byte = cfg_reg;
        `OFF_EVENTS:    rd_byte = {6'h00, rst_flag_reg, trn_flag_reg};
        `OFF_STATUS:    rd_byte = status_reg;
        `OFF_ADDRESS:   rd_byte = {1'b0, addr_reg};
        `OFF_FRAME_LO:  rd_byte = frm_reg[7:0];
        `OFF_FRAME_HI:  rd_byte = {5'h00, frm_reg[10:8]};
        default:        rd_byte = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // usb ram
  // ************************************************************

  // a cpu write to the dual-port ram drops any engine write in that cycle; ownership keeps them apart
  always_ff @(posedge clk_sys_i) begin : usb_ram
    if (wr_en && (dp_hit || bk_hit)) begin
      dp_ram[dp_idx] <= avs_writedata_i[7:0];
    end else if (eng_ram_we_i) begin
      dp_ram[eng_ram_addr_i] <= eng_ram_wdata_i;
    end
    if (wr_en && sp_hit) begin
      sp_ram[sp_idx] <= avs_writedata_i[7:0];
    end
  end

  assign eng_rdata_next = dp_ram[eng_ram_addr_i];

  // engine read port, one cycle latency
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : eng_port
    if (!rst_n_i) begin
      eng_ram_rdata_o <= 8'h00;
    end else begin
      eng_ram_rdata_o <= eng_rdata_next;
    end
  end

  // ************************************************************
  // control and configuration
  // ************************************************************

  // reserved config bits masked to read zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : cfg_regs
    if (!rst_n_i) begin
      ctrl_reg         <= `CTRL_RST;
      cfg_reg          <= `CFG_RST;
      pingpong_clear_o <= 1'b0;
    end else begin
      if (wr_en && avs_address_i == `OFF_MAIN_CTRL) begin
        ctrl_reg <= avs_writedata_i[2:0];
      end
      if (wr_en && avs_address_i == `OFF_CONFIG) begin
        cfg_reg <= avs_writedata_i[7:0] & `CFG_MASK;
      end
      // pulse on the enable's rising write only
      pingpong_clear_o <= wr_en &&
                          avs_address_i == `OFF_MAIN_CTRL &&
                          avs_writedata_i[`CTRL_EN] &&
                          !ctrl_reg[`CTRL_EN];
    end
  end

  assign pingpong_config_o = cfg_reg[1:0];

  a_pp_clear: assert property (
    wr_en && avs_address_i == `OFF_MAIN_CTRL &&
    avs_writedata_i[`CTRL_EN] && !ctrl_reg[`CTRL_EN]
    |=> pingpong_clear_o ##1 !pingpong_clear_o)
    else $error("ping-pong clear not pulsed on enable");

  // ************************************************************
  // transceiver and eye pattern
  // ************************************************************

  assign pu_c  = cfg_reg[`CFG_PU] && ctrl_reg[`CTRL_EN] &&
                 ctrl_reg[`CTRL_CONF];
  assign eye_c = cfg_reg[`CFG_EYE] && ctrl_reg[`CTRL_EN];

  // first eye bit is dp low, dm high: J at low, K at full speed
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : xcvr_ctl
    if (!rst_n_i) begin
      xcvr_o        <= '0;
      eye_phase_reg <= 1'b0;
      sie_clk_run_o <= 1'b0;
    end else begin
      xcvr_o.enable     <= ctrl_reg[`CTRL_EN];
      xcvr_o.full_speed <= cfg_reg[`CFG_FS];
      xcvr_o.dp_pullup  <= pu_c && cfg_reg[`CFG_FS];
      xcvr_o.dm_pullup  <= pu_c && !cfg_reg[`CFG_FS];
      xcvr_o.tx_oe      <= eye_c;
      xcvr_o.tx_dp      <= eye_c && eye_phase_reg;
      xcvr_o.tx_dm      <= eye_c && !eye_phase_reg;
      eye_phase_reg     <= eye_c ? !eye_phase_reg : 1'b0;
      sie_clk_run_o     <= !ctrl_reg[`CTRL_SUSP];
    end
  end

  a_speed_follow: assert property (
    ##1 xcvr_o.full_speed == $past(cfg_reg[`CFG_FS]))
    else $error("speed output does not follow select bit");
  a_xcvr_enable: assert property (
    ctrl_reg[`CTRL_EN] |=> xcvr_o.enable)
    else $error("transceiver not enabled with module");
  a_pullup_gate: assert property (
    !pu_c |=> !xcvr_o.dp_pullup && !xcvr_o.dm_pullup)
    else $error("pull-up active without its conditions");
  a_pullup_side: assert property (
    xcvr_o.dp_pullup || xcvr_o.dm_pullup
    |-> xcvr_o.dp_pullup == xcvr_o.full_speed)
    else $error("pull-up on the wrong data line");
  a_eye_toggle: assert property (
    xcvr_o.tx_oe && $past(xcvr_o.tx_oe)
    |-> xcvr_o.tx_dp != $past(xcvr_o.tx_dp) &&
        xcvr_o.tx_dm == !xcvr_o.tx_dp)
    else $error("eye pattern does not alternate");

  // ************************************************************
  // transfer status fifo and event flags
  // ************************************************************

  assign fifo_full = (count_reg == `FIFO_DEPTH);
  assign push      = done_i.valid && !fifo_full;
  assign pop       = wr_en && avs_address_i == `OFF_EVENTS &&
                     avs_writedata_i[`EVT_TRN] && trn_flag_reg;

  // entry storage, no reset needed
  always_ff @(posedge clk_sys_i) begin : fifo_store
    if (push) begin
      fifo_mem[wr_ptr_reg] <= {done_i.endp, done_i.dir, done_i.pingpong_pointer};
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : fifo_ctl
    if (!rst_n_i) begin
      rd_ptr_reg <= 2'h0;
      wr_ptr_reg <= 2'h0;
      count_reg  <= 3'h0;
      status_reg <= 8'h00;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 2'h1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      end
      case ({push, pop})
        2'b10:   count_reg <= count_reg + 3'h1;
        2'b01:   count_reg <= count_reg - 3'h1;
        default: count_reg <= count_reg;
      endcase
      // stale when empty; software ignores it
      status_reg <= {1'b0, fifo_mem[rd_ptr_reg], 1'b0};
    end
  end

  // flag drops on the pop, returns next cycle if entries remain
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : trn_flag
    if (!rst_n_i) begin
      trn_flag_reg <= 1'b0;
    end else if (pop) begin
      trn_flag_reg <= 1'b0;
    end else if (count_reg != 3'h0) begin
      trn_flag_reg <= 1'b1;
    end
  end

  // bus reset event, write one to clear, set wins
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : rst_flag
    if (!rst_n_i) begin
      rst_flag_reg <= 1'b0;
    end else if (bus_reset_i) begin
      rst_flag_reg <= 1'b1;
    end else if (wr_en && avs_address_i == `OFF_EVENTS &&
                 avs_writedata_i[`EVT_RST]) begin
      rst_flag_reg <= 1'b0;
    end
  end

  a_status_valid: assert property (
    $rose(trn_flag_reg)
    |-> status_reg == {1'b0, fifo_mem[rd_ptr_reg], 1'b0})
    else $error("status not valid when flag rises");
  a_trn_rearm: assert property (
    pop && count_reg > 3'h1 |-> ##[1:TRN_MAX] trn_flag_reg)
    else $error("flag not reasserted after pop");
  a_trn_empty: assert property (
    pop && count_reg == 3'h1 && !push |=> !trn_flag_reg [*2])
    else $error("flag set with empty fifo");

  // ************************************************************
  // endpoint pair control
  // ************************************************************

  // stall bit is clear-only from software; engine set wins
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : ep_ctl
    if (!rst_n_i) begin
      for (int i = 0; i < 8; i++) begin
        ep_reg[i] <= `EP_RST;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wr_en && avs_address_i == `OFF_EP_BASE + 14'(i)) begin
          ep_reg[i] <= {avs_writedata_i[4:1],
                        ep_reg[i][`EP_STALL] &
                        avs_writedata_i[`EP_STALL]};
        end
        if (bus_reset_i) begin
          ep_reg[i][`EP_STALL] <= 1'b0;
        end
        if (stall_i.valid && stall_i.endp == 3'(i)) begin
          ep_reg[i][`EP_STALL] <= 1'b1;
        end
      end
    end
  end

  a_stall_hold: assert property (
    ep_reg[2][`EP_STALL] && !bus_reset_i &&
    !(wr_en && avs_address_i == `OFF_EP_BASE + 14'h2)
    |=> ep_reg[2][`EP_STALL])
    else $error("stall flag lost without a clear");

  // ************************************************************
  // token decisions
  // ************************************************************

  // endpoints above seven are never accepted
  always_comb begin : token_check
    tok_ep = ep_reg[token_i.endp[2:0]];
    case (token_i.kind)
      usb_sie_pkg::TOK_SETUP: tok_ok = !tok_ep[`EP_CDIS];
      usb_sie_pkg::TOK_OUT:   tok_ok = tok_ep[`EP_OUT];
      usb_sie_pkg::TOK_IN:    tok_ok = tok_ep[`EP_IN];
      default:                tok_ok = 1'b0;
    endcase
    acc_c = running && token_i.valid && tok_ok &&
            !token_i.endp[3] &&
            token_i.addr == addr_reg;
  end

  // foreign addresses give no reply at all
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : token_reply
    if (!rst_n_i) begin
      reply_o <= '0;
    end else begin
      reply_o.valid     <= running && token_i.valid &&
                           token_i.kind != usb_sie_pkg::TOK_SOF &&
                           token_i.addr == addr_reg;
      reply_o.accept    <= acc_c;
      reply_o.nak       <= acc_c && fifo_full;
      reply_o.handshake <= acc_c && tok_ep[`EP_HSHK];
    end
  end

  a_nak_full: assert property (
    acc_c && fifo_full |=> reply_o.nak && reply_o.accept)
    else $error("no NAK while status fifo full");
  a_hshk_gate: assert property (
    reply_o.handshake |-> $past(tok_ep[`EP_HSHK]) && reply_o.accept)
    else $error("handshake without handshake enable");

  // ************************************************************
  // address and frame number
  // ************************************************************

  // bus reset beats a software write in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : dev_addr
    if (!rst_n_i) begin
      addr_reg <= `ADDR_RST;
    end else if (bus_reset_i) begin
      addr_reg <= `ADDR_RST;
    end else if (wr_en && avs_address_i == `OFF_ADDRESS) begin
      addr_reg <= avs_writedata_i[6:0];
    end
  end

  // capture stops while suspended, value then goes stale
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin : frame_num
    if (!rst_n_i) begin
      frm_reg <= `FRM_RST;
    end else if (running && token_i.valid &&
                 token_i.kind == usb_sie_pkg::TOK_SOF) begin
      frm_reg <= token_i.frame;
    end
  end

  a_addr_reset: assert property (
    bus_reset_i |=> addr_reg == `ADDR_RST)
    else $error("address not cleared by bus reset");
  a_frame_capture: assert property (
    running && token_i.valid && token_i.kind == usb_sie_pkg::TOK_SOF
    |=> frm_reg == $past(token_i.frame))
    else $error("frame number not captured on sof");

endmodule : usb_device_sie_config_status

// *** usb_host_model.sv ***
// Purpose: host and engine side model for the sie config block
// Assumes: drives by non-blocking assignment on the rising edge
// Notes:   released token fields show the inverse of their last value
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic                clk_sys_i,
  output usb_sie_pkg::token_t      token_o,
  input  wire usb_sie_pkg::reply_t reply_i,
  output usb_sie_pkg::done_t       done_o,
  output usb_sie_pkg::stall_t      stall_o,
  output logic                     bus_reset_o,
  output logic [8:0]               ram_addr_o,
  output logic                     ram_we_o,
  output logic [7:0]               ram_wdata_o,
  input  wire logic [7:0]          ram_rdata_i
);
  // ***************
  // bus transfers
  // ***************
  initial begin
    token_o     = '0;
    done_o      = '0;
    stall_o     = '0;
    bus_reset_o = 1'b0;
    ram_addr_o  = '0;
    ram_we_o    = 1'b0;
    ram_wdata_o = '0;
  end
  // one token; reply sampled at the edge after it stood
  task automatic tok(input usb_sie_pkg::token_t t,
                     output usb_sie_pkg::reply_t r);
    usb_sie_pkg::token_t idle;
    idle       = ~t;
    idle.valid = 1'b0;
    @(posedge clk_sys_i);
    token_o <= t;
    @(posedge clk_sys_i);
    token_o <= idle;
    @(posedge clk_sys_i);
    r = reply_i;
  endtask : tok
  // completions back to back, so the fifo can be filled
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      done_o <= {1'b1, 4'(i + 1), i[0], i[1]};
    end
    @(posedge clk_sys_i);
    done_o <= {1'b0, ~done_o[5:0]};
  endtask : push
  // stall sent on one endpoint pair
  task automatic stall(input logic [2:0] ep);
    @(posedge clk_sys_i);
    stall_o <= {1'b1, ep};
    @(posedge clk_sys_i);
    stall_o <= {1'b0, ~ep};
  endtask : stall
  // usb bus reset seen on the wire
  task automatic brst();
    @(posedge clk_sys_i);
    bus_reset_o <= 1'b1;
    @(posedge clk_sys_i);
    bus_reset_o <= 1'b0;
  endtask : brst
  // engine ram port: data stands one cycle after the address
  task automatic eram(input logic [8:0] a, input logic we,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_i);
    ram_addr_o  <= a;
    ram_we_o    <= we;
    ram_wdata_o <= d;
    @(posedge clk_sys_i);
    ram_we_o <= 1'b0;
    @(posedge clk_sys_i);
    q = ram_rdata_i;
  endtask : eram
endmodule : usb_host_model

// *** tb_top.sv ***
// Purpose: self-checking bench for usb_device_sie_config_status
// Assumes: bench is the firmware, the model is host and engine
// Notes:   token kinds 0..3 are out, in, setup, sof
`timescale 1ns/1ps
module tb_top;
  logic                clk_sys_i, rst_n_i, avs_read_i, avs_write_i;
  logic [13:0]         avs_address_i;
  logic [31:0]         avs_writedata_i, avs_readdata_o;
  logic                avs_waitrequest_o, bus_reset_i, eng_ram_we_i;
  usb_sie_pkg::token_t token_i;
  usb_sie_pkg::reply_t reply_o;
  usb_sie_pkg::done_t  done_i;
  usb_sie_pkg::stall_t stall_i;
  logic [8:0]          eng_ram_addr_i;
  logic [7:0]          eng_ram_wdata_i, eng_ram_rdata_o, b;
  usb_sie_pkg::xcvr_t  xcvr_o, x;
  logic [1:0]          pingpong_config_o;
  logic                pingpong_clear_o, sie_clk_run_o;
  int                  err_total = 0;
  int                  check_count = 0;
  int                  pp_count = 0;
  // ****************
  // harness
  // ****************
  usb_device_sie_config_status dut (
    .clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .token_i,
    .reply_o, .done_i, .stall_i, .bus_reset_i, .eng_ram_addr_i,
    .eng_ram_we_i, .eng_ram_wdata_i, .eng_ram_rdata_o, .xcvr_o,
    .pingpong_config_o, .pingpong_clear_o, .sie_clk_run_o);
  usb_host_model host (
    .clk_sys_i, .token_o(token_i), .reply_i(reply_o), .done_o(done_i),
    .stall_o(stall_i), .bus_reset_o(bus_reset_i),
    .ram_addr_o(eng_ram_addr_i), .ram_we_o(eng_ram_we_i),
    .ram_wdata_o(eng_ram_wdata_i), .ram_rdata_i(eng_ram_rdata_o));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // pointer clears are pulses, so count them
  always @(posedge clk_sys_i) if (pingpong_clear_o === 1'b1) pp_count++;
  // run is a few hundred cycles; cuts a hang
  initial begin
    #2000000;
    err_total++;
    stop_test();
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // avalon access: held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [13:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    avs_writedata_i <= {24'h000000, d};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 100) begin
      err_total++;
      stop_test();
    end
  endtask : bus
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input string n, input logic [13:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(n, {24'h000000, e}, q);
  endtask : rc
  // reply packed as valid, accept, nak, handshake
  task automatic tc(input string n, input logic [1:0] k, input logic [6:0] a,
                    input logic [3:0] ep, input logic [3:0] e);
    usb_sie_pkg::reply_t r;
    host.tok({1'b1, k, a, ep, 11'h5A3}, r);
    chk(n, {28'h0000000, e}, {28'h0000000, r});
  endtask : tc
  // transceiver enable, speed, d+ pull-up, d- pull-up
  task automatic xc(input string n, input logic [3:0] e);
    repeat (3) @(posedge clk_sys_i);
    chk(n, {28'h0000000, e}, {28'h0000000, xcvr_o[6:3]});
  endtask : xc
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // ****************
  // tests
  // ****************
  initial begin
    rst_n_i         = 1'b0;
    avs_address_i   = '0;
    avs_read_i      = 1'b0;
    avs_write_i     = 1'b0;
    avs_writedata_i = '0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    // speed and pull-ups set while disabled
    rc("address", 14'h0004, 8'h00);
    wr(14'h0001, 8'h10);
    xc("xcvr off", 4'h0);
    wr(14'h0000, 8'h01);
    xc("unconfigured", 4'h8);
    wr(14'h0000, 8'h00);
    wr(14'h0000, 8'h05);
    xc("low speed", 4'h9);
    wr(14'h0000, 8'h00);
    wr(14'h0001, 8'h75);
    wr(14'h0000, 8'h05);
    xc("full speed", 4'hE);
    rc("config", 14'h0001, 8'h15);
    chk("pp config", 32'h00000001, {30'h00000000, pingpong_config_o});
    chk("pp clears", 32'h00000003, pp_count);
    $display("test config done");
    // endpoint 1 open, endpoint 2 out only without handshake
    wr(14'h0004, 8'h05);
    wr(14'h0009, 8'h16);
    wr(14'h000A, 8'h0C);
    tc("out ep1", 2'h0, 7'h05, 4'h1, 4'hD);
    tc("in ep1", 2'h1, 7'h05, 4'h1, 4'hD);
    tc("setup ep1", 2'h2, 7'h05, 4'h1, 4'hD);
    tc("setup ep2", 2'h2, 7'h05, 4'h2, 4'h8);
    tc("out ep2", 2'h0, 7'h05, 4'h2, 4'hC);
    tc("in ep2", 2'h1, 7'h05, 4'h2, 4'h8);
    tc("other addr", 2'h0, 7'h06, 4'h1, 4'h0);
    tc("sof", 2'h3, 7'h7F, 4'h0, 4'h0);
    rc("frame lo", 14'h0005, 8'hA3);
    wr(14'h0006, 8'h00);
    rc("frame hi", 14'h0006, 8'h05);
    $display("test tokens done");
    // fill the status fifo, then drain it
    host.push(4);
    repeat (3) @(posedge clk_sys_i);
    tc("fifo full", 2'h0, 7'h05, 4'h1, 4'hF);
    for (int i = 0; i < 4; i++) begin
      rc("trn flag", 14'h0002, 8'h01);
      rc("status", 14'h0003, {1'b0, 4'(i + 1), i[0], i[1], 1'b0});
      wr(14'h0002, 8'h01);
      repeat (7) @(posedge clk_sys_i);
    end
    rc("trn empty", 14'h0002, 8'h00);
    $display("test fifo done");
    host.stall(3'h2);
    rc("stall set", 14'h000A, 8'h0D);
    wr(14'h000A, 8'h0C);
    rc("stall clr", 14'h000A, 8'h0C);
    rc("ep1 ctrl", 14'h0009, 8'h16);
    // cpu and engine share dual-port bytes, banked window included
    wr(14'h2003, 8'hA5);
    host.eram(9'h003, 1'b0, 8'h00, b);
    chk("eng read", 32'h000000A5, {24'h000000, b});
    host.eram(9'h1F1, 1'b1, 8'h3C, b);
    rc("banked", 14'h0371, 8'h3C);
    wr(14'h2200, 8'h77);
    rc("single", 14'h2200, 8'h77);
    rc("unimp", 14'h29AF, 8'h00);
    $display("test ram done");
    host.brst();
    rc("addr cleared", 14'h0004, 8'h00);
    // eye test only with the host model idle
    wr(14'h0001, 8'h95);
    repeat (3) @(posedge clk_sys_i);
    x = xcvr_o;
    @(posedge clk_sys_i);
    chk("eye oe", 32'h00000001, {31'h00000000, xcvr_o.tx_oe});
    chk("eye pair", {30'h00000000, ~x.tx_dp, x.tx_dp},
        {30'h00000000, xcvr_o.tx_dp, xcvr_o.tx_dm});
    wr(14'h0000, 8'h07);
    repeat (3) @(posedge clk_sys_i);
    chk("clk stop", 32'h00000000, {31'h00000000, sie_clk_run_o});
    $display("test modes done");
    stop_test();
  end
endmodule : tb_top
